// ---- pkg/tmr_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_ADDR_CONTROL   8'hC8
`define TMR_ADDR_MODE      8'hC9
`define TMR_ADDR_CNT_LO    8'hCC
`define TMR_ADDR_CNT_HI    8'hCD
`define TMR_ADDR_RLD_LO    8'hCA
`define TMR_ADDR_RLD_HI    8'hCB
`define TMR_CONTROL_RESET  8'h00
`define TMR_MODE_RESET     8'h00
`define TMR_BIT_OVF        7
`define TMR_BIT_EXT        6
`define TMR_BIT_RXSEL      5
`define TMR_BIT_TXSEL      4
`define TMR_BIT_EXEN       3
`define TMR_BIT_RUN        2
`define TMR_BIT_CTSEL      1
`define TMR_BIT_CPRL       0
`define TMR_BIT_CLKOE      1
`define TMR_BIT_DOWN_COUNT_ENABLE       0
`define TMR_MODE_MASK      8'h03
`define TMR_MC_DIV_12CLK   4'hC
`define TMR_MC_DIV_6CLK    4'h6
`define TMR_BAUD_DIV_12CLK 4'h2
`define TMR_BAUD_DIV_6CLK  4'h1
`define TMR_COUNT_ALL_ONES 16'hFFFF
`endif

// ---- pkg/tmr_pkg.sv ----
// types shared by the timer block
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_OFF     = 2'b00,
    TMR_RELOAD  = 2'b01,
    TMR_CAPTURE = 2'b10,
    TMR_BAUD    = 2'b11
  } tmr_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr_bus_t;

  typedef struct packed {
    logic fall;
    logic level;
  } tmr_pin_t;
endpackage

// ---- test/tmr_serial_model.sv ----
// serial port side model: counts baud pulses and derives bit counts
`timescale 1ns/100ps
module tmr_serial_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic tx_baud_tick,
  input  wire logic rx_baud_tick,
  output int        tx_ticks,
  output int        rx_ticks,
  output int        tx_bits,
  output int        rx_bits
);
  always @(posedge core_clk) begin
    if (!reset_n) begin
      tx_ticks <= 0;
      rx_ticks <= 0;
    end else begin
      tx_ticks <= tx_ticks + int'(tx_baud_tick);
      rx_ticks <= rx_ticks + int'(rx_baud_tick);
    end
  end
  // one serial bit per sixteen rollovers
  assign tx_bits = tx_ticks / 16;
  assign rx_bits = rx_ticks / 16;
endmodule

// ---- test/tmr_timer2_bench.sv ----
// self-checking bench for the timer block
`timescale 1ns/100ps
module tmr_timer2_bench;
  import tmr_pkg::*;
  logic       core_clk    = 1'b0;
  logic       reset_n     = 1'b0;
  logic       six_clock   = 1'b0;
  logic       trigger_pin = 1'b1;
  logic       count_pin   = 1'b1;
  tmr_bus_t   bus         = '0;
  logic [7:0] bus_rdata;
  logic       timer_irq;
  logic       tx_baud_tick;
  logic       rx_baud_tick;
  logic       tx_from_timer2;
  logic       rx_from_timer2;
  int         tx_ticks;
  int         rx_ticks;
  int         bad_count   = 0;
  int         checked     = 0;

  always #25 core_clk = ~core_clk;

  tmr_timer2 tmr_timer2_i (.core_clk(core_clk), .reset_n(reset_n), .six_clock(six_clock),
    .trigger_pin(trigger_pin), .count_pin(count_pin), .bus_addr(bus.addr),
    .bus_wdata(bus.wdata), .bus_wr(bus.wr), .bus_rd(bus.rd), .bus_rdata(bus_rdata),
    .timer_irq(timer_irq), .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick),
    .tx_from_timer2(tx_from_timer2), .rx_from_timer2(rx_from_timer2));

  tmr_serial_model tmr_serial_model_i (.core_clk(core_clk), .reset_n(reset_n),
    .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick), .tx_ticks(tx_ticks),
    .rx_ticks(rx_ticks), .tx_bits(), .rx_bits());

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus <= '0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus <= '0;
    #1 check(what, exp, bus_rdata);
  endtask

  task automatic load(logic [7:0] a, logic [15:0] v);
    wr(a + 8'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'hC8, 8'h00, "control reset");
    rd(8'hC9, 8'h00, "mode reset");
    rd(8'h50, 8'h00, "unmapped");
    wr(8'hC9, 8'hFF);
    rd(8'hC9, 8'h03, "mode reserved bits");
    wr(8'hC9, 8'h00);
    check("tx select", 8'h00, {7'h00, tx_from_timer2});
  endtask

  task automatic t_reload();
    load(8'hCA, 16'h1234);
    load(8'hCC, 16'hFFFE);
    wr(8'hC8, 8'h04);
    cyc(60);
    rd(8'hC8, 8'h84, "overflow flag");
    rd(8'hCD, 8'h12, "reloaded high");
    check("irq", 8'h01, {7'h00, timer_irq});
    cyc(20);
    rd(8'hC8, 8'h84, "flag held");
    wr(8'hC8, 8'h04);
    cyc(3);
    check("irq cleared", 8'h00, {7'h00, timer_irq});
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h55);
    cyc(100);
    rd(8'hCC, 8'h55, "stopped count");
    load(8'hCC, 16'h4000);
    wr(8'hC8, 8'h0C);
    cyc(5);
    trigger_pin <= 1'b0;
    cyc(10);
    rd(8'hCD, 8'h12, "edge reload");
    rd(8'hC8, 8'h4C, "reload ext flag");
    wr(8'hC8, 8'h00);
    trigger_pin <= 1'b1;
  endtask

  task automatic t_counter();
    load(8'hCC, 16'h0000);
    wr(8'hC8, 8'h06);
    repeat (5) begin
      cyc(4);
      count_pin <= 1'b0;
      cyc(4);
      count_pin <= 1'b1;
    end
    cyc(6);
    rd(8'hCC, 8'h05, "edge count");
    wr(8'hC8, 8'h00);
  endtask

  task automatic t_capture();
    load(8'hCC, 16'hFFFF);
    wr(8'hC8, 8'h05);
    cyc(30);
    rd(8'hCD, 8'h00, "capture rollover");
    rd(8'hC8, 8'h85, "capture overflow");
    wr(8'hC8, 8'h00);
    load(8'hCC, 16'h2000);
    wr(8'hC8, 8'h0D);
    cyc(5);
    trigger_pin <= 1'b0;
    cyc(10);
    rd(8'hCB, 8'h20, "captured high");
    rd(8'hC8, 8'h4D, "external flag");
    check("irq ext", 8'h01, {7'h00, timer_irq});
    cyc(1);
    trigger_pin <= 1'b1;
    cyc(29);
    rd(8'hCD, 8'h20, "no reload");
    wr(8'hC8, 8'h00);
  endtask

  task automatic t_down();
    wr(8'hC9, 8'h01);
    load(8'hCA, 16'h0100);
    load(8'hCC, 16'h0102);
    trigger_pin <= 1'b0;
    cyc(4);
    wr(8'hC8, 8'h04);
    cyc(80);
    rd(8'hCD, 8'hFF, "underflow load");
    rd(8'hC8, 8'hC4, "wrap flags");
    wr(8'hC8, 8'h44);
    cyc(3);
    check("ext no irq", 8'h00, {7'h00, timer_irq});
    wr(8'hC8, 8'h00);
    load(8'hCC, 16'hFFFE);
    trigger_pin <= 1'b1;
    cyc(4);
    wr(8'hC8, 8'h04);
    cyc(40);
    rd(8'hCD, 8'h01, "up reload high");
    rd(8'hC8, 8'hC4, "up wrap flags");
    wr(8'hC8, 8'h00);
    wr(8'hC9, 8'h00);
  endtask

  task automatic baud_run(logic six, logic [7:0] ctl, int exp_tx, int exp_rx);
    int tx0;
    int rx0;
    wr(8'hC8, 8'h00);
    six_clock <= six;
    load(8'hCA, 16'hFFF0);
    load(8'hCC, 16'hFFF0);
    tx0 = tx_ticks;
    rx0 = rx_ticks;
    wr(8'hC8, ctl);
    cyc(512);
    checked++;
    if (tx_ticks - tx0 < exp_tx - 1 || tx_ticks - tx0 > exp_tx + 1 ||
        rx_ticks - rx0 < exp_rx - 1 || rx_ticks - rx0 > exp_rx + 1) begin
      bad_count++;
      $display("CHECK FAILED baud ticks expected %0d %0d seen %0d %0d", exp_tx, exp_rx,
               tx_ticks - tx0, rx_ticks - rx0);
    end
    rd(8'hC8, ctl, "baud no flag");
    check("baud irq", 8'h00, {7'h00, timer_irq});
    check("selects", {6'h00, ctl[5:4]}, {6'h00, rx_from_timer2, tx_from_timer2});
  endtask

  task automatic t_baud();
    baud_run(1'b1, 8'h34, 32, 32);
    baud_run(1'b0, 8'h34, 16, 16);
    baud_run(1'b1, 8'h14, 32, 0);
    wr(8'hC8, 8'h3C);
    trigger_pin <= 1'b0;
    cyc(10);
    rd(8'hC8, 8'h7C, "baud ext flag");
    check("baud ext irq", 8'h01, {7'h00, timer_irq});
    wr(8'hC8, 8'h00);
    trigger_pin <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    reset_n <= 1'b1;
    t_reset();
    t_reload();
    t_counter();
    t_capture();
    t_down();
    t_baud();
    final_report();
  end

  initial begin
    #(50 * 20000);
    bad_count++;
    final_report();
  end
endmodule

// ---- verilog/tmr_pin_sync.sv ----
// two-flop synchroniser with falling-edge detect for a pin
`timescale 1ns/100ps
module tmr_pin_sync
  import tmr_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     reset_n,
  input  wire logic     pin,
  output tmr_pin_t      pin_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign pin_o.level = sync_q;
  assign pin_o.fall  = last_q & ~sync_q;
endmodule

// ---- verilog/tmr_prescale.sv ----
// divider giving one-cycle tick pulses for machine cycle and baud timing
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_prescale
  import tmr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic six_clock,
  input  wire logic baud_rate,
  output logic      tick
);
  logic [3:0] cnt_q;
  logic [3:0] div;

  assign div = baud_rate ? (six_clock ? `TMR_BAUD_DIV_6CLK : `TMR_BAUD_DIV_12CLK)
                         : (six_clock ? `TMR_MC_DIV_6CLK : `TMR_MC_DIV_12CLK);
  assign tick = (cnt_q >= div - 4'h1);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= tick ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule

// ---- verilog/tmr_timer2.sv ----
// 16-bit timer/counter with capture, auto-reload and baud generator modes
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_timer2
  import tmr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       six_clock,
  input  wire logic       trigger_pin,
  input  wire logic       count_pin,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  output logic            timer_irq,
  output logic            tx_baud_tick,
  output logic            rx_baud_tick,
  output logic            tx_from_timer2,
  output logic            rx_from_timer2
);
  ////////////////////////////////////////////////////////////////////////////////
  tmr_bus_t   bus;
  tmr_pin_t   trig;
  tmr_pin_t   cpin;
  logic [7:0] control_q;
  logic [7:0] mode_q;
  logic [7:0] rdata_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] reload_q;
  logic [15:0] reload_d;
  logic       ovf_set;
  logic       ext_set;
  logic       ext_toggle;
  logic       irq_q;
  logic       tx_tick_q;
  logic       rx_tick_q;
  logic       tx_sel_q;
  logic       rx_sel_q;
  logic       int_tick;
  logic       step;
  logic       at_top;
  logic       at_floor;
  logic       going_down;
  logic       wrap;
  logic       trig_fall_en;
  logic       do_capture;
  logic       do_reload;
  tmr_mode_t  mode;

  assign bus = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

  function automatic logic [7:0] byte_sel(input logic [15:0] v, input logic hi);
    byte_sel = hi ? v[15:8] : v[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  tmr_pin_sync u_trig_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (trigger_pin),
    .pin_o    (trig)
  );

  tmr_pin_sync u_count_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (count_pin),
    .pin_o    (cpin)
  );

  tmr_prescale u_prescale (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .six_clock (six_clock),
    .baud_rate (mode == TMR_BAUD),
    .tick      (int_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  wire baud_sel = control_q[`TMR_BIT_RXSEL] | control_q[`TMR_BIT_TXSEL];
  assign mode = !control_q[`TMR_BIT_RUN] ? TMR_OFF :
                baud_sel ? TMR_BAUD :
                control_q[`TMR_BIT_CPRL] ? TMR_CAPTURE : TMR_RELOAD;

  wire run      = (mode != TMR_OFF);
  assign step   = run & (control_q[`TMR_BIT_CTSEL] ? cpin.fall : int_tick);
  wire down_count_enable     = mode_q[`TMR_BIT_DOWN_COUNT_ENABLE];
  assign going_down = (mode == TMR_RELOAD) & down_count_enable & ~trig.level;
  assign at_top     = (count_q == `TMR_COUNT_ALL_ONES);
  assign at_floor   = (count_q == reload_q);
  assign wrap       = step & (going_down ? at_floor : at_top);
  assign trig_fall_en = run & control_q[`TMR_BIT_EXEN] & trig.fall;
  assign do_capture = (mode == TMR_CAPTURE) & trig_fall_en;
  assign do_reload  = (mode == TMR_RELOAD) & ~down_count_enable & trig_fall_en;

  // overflow flag: not in baud mode, never reload in capture mode
  assign ovf_set = wrap & (mode != TMR_BAUD);
  // external flag: trigger edge except in down-count mode, where it toggles
  assign ext_set = trig_fall_en & ~((mode == TMR_RELOAD) & down_count_enable);
  assign ext_toggle = wrap & (mode == TMR_RELOAD) & down_count_enable;

  ////////////////////////////////////////////////////////////////////////////////
  wire wr_cnt_lo = bus.wr & (bus.addr == `TMR_ADDR_CNT_LO);
  wire wr_cnt_hi = bus.wr & (bus.addr == `TMR_ADDR_CNT_HI);
  wire wr_rld_lo = bus.wr & (bus.addr == `TMR_ADDR_RLD_LO);
  wire wr_rld_hi = bus.wr & (bus.addr == `TMR_ADDR_RLD_HI);
  wire wr_ctrl   = bus.wr & (bus.addr == `TMR_ADDR_CONTROL);
  wire wr_mode   = bus.wr & (bus.addr == `TMR_ADDR_MODE);

  always_comb begin
    count_d = count_q;
    if (wrap) begin
      if (going_down) begin
        count_d = `TMR_COUNT_ALL_ONES;
      end else if (mode == TMR_CAPTURE) begin
        count_d = 16'h0000;
      end else begin
        count_d = reload_q;
      end
    end else if (do_reload) begin
      count_d = reload_q;
    end else if (step) begin
      count_d = going_down ? count_q - 16'h0001 : count_q + 16'h0001;
    end
    // software access; expected only with the timer stopped
    if (wr_cnt_lo) begin
      count_d[7:0] = bus.wdata;
    end
    if (wr_cnt_hi) begin
      count_d[15:8] = bus.wdata;
    end
  end

  always_comb begin
    reload_d = reload_q;
    if (do_capture) begin
      reload_d = count_q;
    end
    if (wr_rld_lo) begin
      reload_d[7:0] = bus.wdata;
    end
    if (wr_rld_hi) begin
      reload_d[15:8] = bus.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_q  <= 16'h0000;
      reload_q <= 16'h0000;
    end else begin
      count_q  <= count_d;
      reload_q <= reload_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register; hardware set wins over software clear
  wire [7:0] ctrl_wr = wr_ctrl ? bus.wdata : control_q;
  wire       ovf_d   = ctrl_wr[`TMR_BIT_OVF] | ovf_set;
  wire       ext_d   = ext_toggle ? ~control_q[`TMR_BIT_EXT]
                                  : (ctrl_wr[`TMR_BIT_EXT] | ext_set);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      control_q <= `TMR_CONTROL_RESET;
      mode_q    <= `TMR_MODE_RESET;
    end else begin
      control_q <= {ovf_d, ext_d, ctrl_wr[5:0]};
      if (wr_mode) begin
        mode_q <= bus.wdata & `TMR_MODE_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  wire [7:0] rd_mux =
    (bus.addr == `TMR_ADDR_CONTROL) ? control_q :
    (bus.addr == `TMR_ADDR_MODE)    ? mode_q :
    (bus.addr == `TMR_ADDR_CNT_LO)  ? byte_sel(count_q, 1'b0) :
    (bus.addr == `TMR_ADDR_CNT_HI)  ? byte_sel(count_q, 1'b1) :
    (bus.addr == `TMR_ADDR_RLD_LO)  ? byte_sel(reload_q, 1'b0) :
    (bus.addr == `TMR_ADDR_RLD_HI)  ? byte_sel(reload_q, 1'b1) : 8'h00;

  // interrupt: external flag excluded while counting up/down
  wire irq_d = control_q[`TMR_BIT_OVF] |
               (control_q[`TMR_BIT_EXT] & ~(down_count_enable & (mode == TMR_RELOAD)));
  wire baud_wrap = wrap & (mode == TMR_BAUD);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_q   <= 8'h00;
      irq_q     <= 1'b0;
      tx_tick_q <= 1'b0;
      rx_tick_q <= 1'b0;
      tx_sel_q  <= 1'b0;
      rx_sel_q  <= 1'b0;
    end else begin
      rdata_q   <= bus.rd ? rd_mux : 8'h00;
      irq_q     <= irq_d;
      tx_tick_q <= baud_wrap & control_q[`TMR_BIT_TXSEL];
      rx_tick_q <= baud_wrap & control_q[`TMR_BIT_RXSEL];
      tx_sel_q  <= control_q[`TMR_BIT_TXSEL];
      rx_sel_q  <= control_q[`TMR_BIT_RXSEL];
    end
  end

  assign bus_rdata      = rdata_q;
  assign timer_irq      = irq_q;
  assign tx_baud_tick   = tx_tick_q;
  assign rx_baud_tick   = rx_tick_q;
  assign tx_from_timer2 = tx_sel_q;
  assign rx_from_timer2 = rx_sel_q;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_up_wrap;
    step && at_top && !going_down && mode == TMR_RELOAD;
  endsequence

  sequence s_ovf_seen;
    ovf_set ##1 1'b1;
  endsequence

  sequence s_ext_raise;
    ext_set && !wr_ctrl && !wr_mode ##1 1'b1;
  endsequence

  a_reload_on_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
    (s_up_wrap and (!wr_cnt_lo && !wr_cnt_hi)) |=> count_q == $past(reload_q))
    else $error("count not reloaded on rollover");

  a_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    ovf_set |=> control_q[`TMR_BIT_OVF])
    else $error("overflow flag not set");

  a_down_floor_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    wrap && going_down && !wr_cnt_lo && !wr_cnt_hi |=> count_q == `TMR_COUNT_ALL_ONES)
    else $error("underflow did not load all ones");

  a_capture_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
    do_capture && !wr_rld_lo && !wr_rld_hi |=> reload_q == $past(count_q))
    else $error("capture did not copy count");

  a_baud_no_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_BAUD && !wr_ctrl && !control_q[`TMR_BIT_OVF] |=> !control_q[`TMR_BIT_OVF])
    else $error("baud rollover set overflow flag");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    control_q[`TMR_BIT_OVF] && !wr_ctrl |=> control_q[`TMR_BIT_OVF])
    else $error("overflow flag cleared by hardware");

  a_stopped_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_OFF && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_q))
    else $error("count moved while stopped");

  a_irq_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_ovf_seen |=> timer_irq)
    else $error("interrupt not raised after overflow");

  a_ext_toggle: assert property (@(posedge core_clk) disable iff (!reset_n)
    ext_toggle |=> control_q[`TMR_BIT_EXT] != $past(control_q[`TMR_BIT_EXT]))
    else $error("external flag did not toggle");

  a_baud_no_reload: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_BAUD && trig.fall && !step && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_q))
    else $error("trigger edge reloaded in baud mode");

  a_ext_irq: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_ext_raise |=> timer_irq)
    else $error("interrupt not raised after external flag");

  a_ext_on_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
    ext_set |=> control_q[`TMR_BIT_EXT])
    else $error("external flag not set on trigger edge");

  a_ext_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    control_q[`TMR_BIT_EXT] && !wr_ctrl && !ext_toggle |=> control_q[`TMR_BIT_EXT])
    else $error("external flag cleared by hardware");

  a_down_count_enable_ext_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_RELOAD && down_count_enable && !ext_toggle && !wr_ctrl |=> $stable(control_q[`TMR_BIT_EXT]))
    else $error("external flag moved without wrap in up/down mode");

  a_irq_ext_masked: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_RELOAD && down_count_enable && !control_q[`TMR_BIT_OVF] |=> !timer_irq)
    else $error("external flag raised interrupt in up/down mode");

  a_capture_wrap_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_CAPTURE && wrap && !wr_cnt_lo && !wr_cnt_hi |=> count_q == 16'h0000)
    else $error("capture mode reloaded on rollover");

  a_edge_reload: assert property (@(posedge core_clk) disable iff (!reset_n)
    do_reload && !wr_cnt_lo && !wr_cnt_hi |=> count_q == $past(reload_q))
    else $error("trigger edge did not reload count");

  a_baud_reload: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == TMR_BAUD && wrap && !wr_cnt_lo && !wr_cnt_hi |=> count_q == $past(reload_q))
    else $error("baud rollover did not reload count");

  a_up_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    step && !wrap && !do_reload && !going_down && !wr_cnt_lo && !wr_cnt_hi |=>
      count_q == $past(count_q) + 16'h0001)
    else $error("count did not step up");

  a_down_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    step && going_down && !wrap && !wr_cnt_lo && !wr_cnt_hi |=>
      count_q == $past(count_q) - 16'h0001)
    else $error("count did not step down");

  a_tx_tick: assert property (@(posedge core_clk) disable iff (!reset_n)
    baud_wrap && control_q[`TMR_BIT_TXSEL] |=> tx_baud_tick)
    else $error("transmit baud pulse missing");

  a_rx_tick: assert property (@(posedge core_clk) disable iff (!reset_n)
    baud_wrap && control_q[`TMR_BIT_RXSEL] |=> rx_baud_tick)
    else $error("receive baud pulse missing");

  a_tx_sel_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
    control_q[`TMR_BIT_TXSEL] |=> tx_from_timer2)
    else $error("transmit select not routed");
endmodule
